// File: mms_master.sv
// Management serial master: host registers, frame engine on the link clock
// Operation
// - Every PHY access runs over MDC driven out and bidirectional MDIO.
// - Frames carry a 5-bit PHY address and a 5-bit register address.
// - Data register is shifted out on writes and filled from MDIO on reads.
// - A write to the upper command byte while idle starts a read or write frame.
// - Data and command/status registers sit on the normal register port.
// - Bit 15 goes high once a read or write frame has finished.
// - After a read the data register takes the result in the same cycle that bit 15 rises.
// - With bit 14 set, completion of either operation raises the interrupt.
// - Any access to the upper command byte clears the pending interrupt.
// - MDC stays low except while an operation is running.
`timescale 1ns/100ps
`default_nettype none

module mms_master #(
	parameter int HALF_BASE = mms_pkg::MDC_HALF_BASE
) (
	// Host clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link clock for the frame engine
	input wire logic link_clk,
	// Register port
	input wire logic reg_sel_data,
	input wire logic reg_sel_cmd,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] reg_be,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Completion interrupt and activity
	output logic mgmt_irq,
	output logic mgmt_busy,
	// Management pins
	output logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe
);
	import mms_pkg::*;

	// Refuse settings the divider cannot serve
	generate
		if (HALF_BASE < 2 || HALF_BASE > 16) begin : g_bad_half
			$error("mms_master: HALF_BASE must lie in 2..16");
		end
	endgenerate

	typedef enum logic [1:0] {
		MMS_IDLE = 2'b00,
		MMS_RUN = 2'b01
	} mms_state_e;

	// True when an access touches the upper command byte
	function automatic logic upper_hit(input logic sel, input logic acc, input logic be1);
		upper_hit = sel & acc & be1;
	endfunction : upper_hit

	// Builds the 64-bit frame from the command fields and data
	function automatic logic [63:0] build_frame(input logic [14:0] cmd, input logic [15:0] dat);
		logic [1:0] op;
		op = cmd[CMD_WRITE_BIT] ? FRM_OP_WR : FRM_OP_RD;
		build_frame = {FRM_PREAMBLE, FRM_START, op, cmd[CMD_PHY_MSB:CMD_PHY_LSB],
			cmd[CMD_REG_MSB:CMD_REG_LSB], FRM_TA_WR, dat};
	endfunction : build_frame

	// Host domain state
	logic [15:0] data_q;
	logic [14:0] cmd_q;
	logic done_q;
	logic irq_q;
	logic busy_q;
	logic start_tgl_q;
	logic [15:0] rdata_q;
	logic done_evt;
	logic cmd_wr_hi;
	logic cmd_wr_lo;
	logic start_req;
	logic upper_acc;

	// Link domain state
	logic lrst_s1_q;
	logic lrstn_q;
	logic start_evt;
	mms_state_e state_q;
	logic [6:0] div_q;
	logic [6:0] half_cnt;
	logic [5:0] bit_q;
	logic mdc_q;
	logic [63:0] frame_q;
	logic rd_op_q;
	logic mdio_o_q;
	logic mdio_oe_q;
	logic mdio_s1_q;
	logic mdio_s2_q;
	logic [15:0] rx_q;
	logic done_tgl_q;
	logic half_end;
	logic mdc_rise;
	logic mdc_fall;
	logic frame_end;

	// Register port decode
	assign cmd_wr_hi = upper_hit(reg_sel_cmd, reg_wr, reg_be[1]) & ~busy_q;
	assign cmd_wr_lo = reg_sel_cmd & reg_wr & reg_be[0] & ~busy_q;
	assign start_req = cmd_wr_hi;
	assign upper_acc = upper_hit(reg_sel_cmd, reg_wr | reg_rd, reg_be[1]);

	// Command fields, written by byte lane while idle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_q <= CMD_RESET;
		end else begin
			if (cmd_wr_lo) begin
				cmd_q[7:0] <= reg_wdata[7:0];
			end
			if (cmd_wr_hi) begin
				cmd_q[14:8] <= reg_wdata[14:8];
			end
		end
	end

	// Data register: host writes, or the read result on completion
	always_ff @(posedge clk) begin
		if (!rstn) begin
			data_q <= DATA_RESET;
		end else if (done_evt && !cmd_q[CMD_WRITE_BIT]) begin
			data_q <= rx_q;
		end else if (reg_sel_data && reg_wr && !busy_q) begin
			if (reg_be[0]) begin
				data_q[7:0] <= reg_wdata[7:0];
			end
			if (reg_be[1]) begin
				data_q[15:8] <= reg_wdata[15:8];
			end
		end
	end

	// Busy flag and start toggle towards the link domain
	always_ff @(posedge clk) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			start_tgl_q <= 1'b0;
		end else if (start_req) begin
			busy_q <= 1'b1;
			start_tgl_q <= ~start_tgl_q;
		end else if (done_evt) begin
			busy_q <= 1'b0;
		end
	end

	// Completion flag, cleared on start
	always_ff @(posedge clk) begin
		if (!rstn) begin
			done_q <= 1'b0;
		end else if (done_evt) begin
			done_q <= 1'b1;
		end else if (start_req) begin
			done_q <= 1'b0;
		end
	end

	// Interrupt: completion sets, upper byte access clears, set wins
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else if (done_evt && cmd_q[CMD_IE_BIT]) begin
			irq_q <= 1'b1;
		end else if (upper_acc) begin
			irq_q <= 1'b0;
		end
	end

	// Registered read data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd && reg_sel_data) begin
			rdata_q <= data_q;
		end else if (reg_rd && reg_sel_cmd) begin
			rdata_q <= {done_q, cmd_q};
		end
	end

	assign reg_rdata = rdata_q;
	assign mgmt_irq = irq_q;
	assign mgmt_busy = busy_q;

	// Completion event into the host domain
	mms_tsync u_done_sync (
		.clk(clk),
		.rstn(rstn),
		.tgl_in(done_tgl_q),
		.evt(done_evt)
	);

	// Reset for the link domain
	always_ff @(posedge link_clk) begin
		lrst_s1_q <= rstn;
		lrstn_q <= lrst_s1_q;
	end

	// Start event into the link domain
	mms_tsync u_start_sync (
		.clk(link_clk),
		.rstn(lrstn_q),
		.tgl_in(start_tgl_q),
		.evt(start_evt)
	);

	// MDIO input synchroniser
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			mdio_s1_q <= 1'b0;
			mdio_s2_q <= 1'b0;
		end else begin
			mdio_s1_q <= mdio_i;
			mdio_s2_q <= mdio_s1_q;
		end
	end

	// Half period from the multiplier field, stable while busy
	assign half_cnt = 7'((32'(cmd_q[CMD_MUL_MSB:CMD_MUL_LSB]) + 1) * HALF_BASE - 1);

	// Sequencer strobes: end of a half period and the MDC edge it makes
	assign half_end = (state_q == MMS_RUN) && (div_q == half_cnt);
	assign mdc_rise = half_end && !mdc_q;
	assign mdc_fall = half_end && mdc_q;
	assign frame_end = mdc_fall && (bit_q == FRM_LAST_BIT);

	// Engine state: idle until the start event, idle again after the last bit
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			state_q <= MMS_IDLE;
		end else begin
			case (state_q)
				MMS_IDLE: begin
					if (start_evt) begin
						state_q <= MMS_RUN;
					end
				end
				MMS_RUN: begin
					if (frame_end) begin
						state_q <= MMS_IDLE;
					end
				end
				default: begin
					state_q <= MMS_IDLE;
				end
			endcase
		end
	end

	// Half period divider, held at zero outside a frame
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			div_q <= 7'h00;
		end else if (state_q != MMS_RUN || half_end) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end

	// Bit counter, one step per falling MDC
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			bit_q <= 6'h00;
		end else if (state_q != MMS_RUN) begin
			bit_q <= 6'h00;
		end else if (mdc_fall && !frame_end) begin
			bit_q <= bit_q + 6'h01;
		end
	end

	// MDC: parked low while idle, toggled at each half period end
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			mdc_q <= 1'b0;
		end else if (state_q != MMS_RUN) begin
			mdc_q <= 1'b0;
		end else if (half_end) begin
			mdc_q <= ~mdc_q;
		end
	end

	// Completion toggle towards the host domain
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			done_tgl_q <= 1'b0;
		end else if (frame_end) begin
			done_tgl_q <= ~done_tgl_q;
		end
	end

	// Outgoing shift: load on start, next bit after each falling MDC
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			frame_q <= 64'h0;
			rd_op_q <= 1'b0;
			mdio_o_q <= 1'b0;
		end else if (state_q == MMS_IDLE && start_evt) begin
			frame_q <= build_frame(cmd_q, data_q);
			rd_op_q <= ~cmd_q[CMD_WRITE_BIT];
			mdio_o_q <= 1'b1;
		end else if (mdc_fall) begin
			frame_q <= {frame_q[62:0], 1'b0};
			mdio_o_q <= frame_q[62];
		end
	end

	// Drive enable: whole write frame, read frame up to turnaround
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			mdio_oe_q <= 1'b0;
		end else if (state_q == MMS_IDLE) begin
			mdio_oe_q <= start_evt;
		end else if (mdc_fall) begin
			if (bit_q == FRM_LAST_BIT) begin
				mdio_oe_q <= 1'b0;
			end else if (rd_op_q && (bit_q + 6'h01) >= FRM_RD_DRIVE_END) begin
				mdio_oe_q <= 1'b0;
			end
		end
	end

	// Read data captured on rising MDC, most significant first
	always_ff @(posedge link_clk) begin
		if (!lrstn_q) begin
			rx_q <= 16'h0000;
		end else if (mdc_rise && rd_op_q && bit_q >= FRM_DATA_FIRST) begin
			rx_q <= {rx_q[14:0], mdio_s2_q};
		end
	end

	// Pin outputs
	assign mdc = mdc_q;
	assign mdio_o = mdio_o_q;
	assign mdio_oe = mdio_oe_q;
endmodule : mms_master

`default_nettype wire

// File: mms_tsync.sv
// Shared constants and the toggle event synchroniser for the management master
`timescale 1ns/100ps
`default_nettype none

package mms_pkg;
	// Command/status field positions
	localparam int CMD_PHY_LSB = 0;
	localparam int CMD_PHY_MSB = 4;
	localparam int CMD_MUL_LSB = 5;
	localparam int CMD_MUL_MSB = 7;
	localparam int CMD_REG_LSB = 8;
	localparam int CMD_REG_MSB = 12;
	localparam int CMD_WRITE_BIT = 13;
	localparam int CMD_IE_BIT = 14;
	localparam int CMD_DONE_BIT = 15;
	// Reset values
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [14:0] CMD_RESET = 15'h0000;
	// Management frame layout, bit 63 goes out first
	localparam logic [31:0] FRM_PREAMBLE = 32'hffff_ffff;
	localparam logic [1:0] FRM_START = 2'h1;
	localparam logic [1:0] FRM_OP_WR = 2'h1;
	localparam logic [1:0] FRM_OP_RD = 2'h2;
	localparam logic [1:0] FRM_TA_WR = 2'h2;
	localparam logic [5:0] FRM_LAST_BIT = 6'h3f;
	localparam logic [5:0] FRM_RD_DRIVE_END = 6'h2e;
	localparam logic [5:0] FRM_DATA_FIRST = 6'h30;
	// MDC half period in link clocks per multiplier step
	localparam int MDC_HALF_BASE = 4;
endpackage : mms_pkg

module mms_tsync (
	// Destination clock and synchronous reset
	input wire logic clk,
	input wire logic rstn,
	// Toggle from the other domain
	input wire logic tgl_in,
	// One-cycle event in this domain
	output logic evt
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Two-flop synchroniser, third flop for edge detection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= tgl_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Any change of the toggle is one event
	assign evt = s2_q ^ s3_q;
endmodule : mms_tsync

`default_nettype wire

// File: mms_chk.sv
// Port checker for the management master
`timescale 1ns/100ps
`default_nettype none
module mms_chk (
	// Clocks and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	// Register port
	input wire logic reg_sel_data,
	input wire logic reg_sel_cmd,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] reg_be,
	// Status and pins
	input wire logic mgmt_irq,
	input wire logic mgmt_busy,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe
);
	// Upper command byte access
	wire logic cmd_hi = reg_sel_cmd && !reg_sel_data && reg_be[1];
	a_mdc_idle: assert property (@(posedge link_clk) disable iff (!rstn)
		!mgmt_busy |-> !mdc) else $error("mdc active while idle");
	a_oe_idle: assert property (@(posedge link_clk) disable iff (!rstn)
		!mgmt_busy |-> !mdio_oe) else $error("mdio driven while idle");
	a_cmd_start: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && cmd_hi && !mgmt_busy |=> mgmt_busy) else $error("no start");
	a_irq_clear: assert property (@(posedge clk) disable iff (!rstn)
		(reg_wr || reg_rd) && cmd_hi && !mgmt_busy |=> !mgmt_irq) else $error("irq kept");
	a_irq_idle: assert property (@(posedge clk) disable iff (!rstn)
		mgmt_irq |-> !mgmt_busy) else $error("irq while busy");
	a_irq_rise: assert property (@(posedge clk) disable iff (!rstn)
		$rose(mgmt_irq) |-> $fell(mgmt_busy)) else $error("irq not at completion");
	a_frame_open: assert property (@(posedge link_clk) disable iff (!rstn)
		$rose(mdio_oe) |-> mdio_o && !mdc) else $error("bad frame start");
	a_bit_timing: assert property (@(posedge link_clk) disable iff (!rstn)
		mdio_oe && $past(mdio_oe) && $changed(mdio_o) |-> $past(mdc) && !mdc)
		else $error("mdio moved off the falling mdc");
	a_mdc_half: assert property (@(posedge link_clk) disable iff (!rstn)
		$rose(mdc) |=> mdc) else $error("mdc high too short");
endmodule : mms_chk
bind mms_master mms_chk u_chk (.clk, .rstn, .link_clk, .reg_sel_data, .reg_sel_cmd,
	.reg_wr, .reg_rd, .reg_be, .mgmt_irq, .mgmt_busy, .mdc, .mdio_o, .mdio_oe);
`default_nettype wire

// File: mms_phy.sv
// Behavioural PHY management port
`timescale 1ns/100ps
`default_nettype none
module mms_phy #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Management pins
	input wire logic mdc,
	input wire logic mdio,
	// Drive back onto the line
	output logic drv_o,
	output logic drv_oe
);
	logic [15:0] mem [32];
	logic [63:0] sh;
	logic [5:0] pos;
	logic [4:0] ra;
	logic [1:0] op;
	logic hit;
	wire logic [63:0] s = {sh[62:0], mdio};
	// Known register contents
	initial begin
		{pos, sh, drv_o, drv_oe, hit, op, ra} = 0;
		for (int i = 0; i < 32; i++) mem[i] = {11'h2d3, 5'(i)};
	end
	// Frame decode on rising mdc, drive after it
	always @(posedge mdc) begin
		sh <= s;
		pos <= (pos != 0) ? pos + 6'h1 : (s[33:0] == 34'h3_ffff_fffd) ? 6'h22 : 6'h0;
		if (pos == 6'h2d) begin
			hit <= s[9:5] == PHY_ADDR;
			op <= s[11:10];
			ra <= s[4:0];
		end
		if (pos == 6'h2e) drv_oe <= hit && op == 2'h2;
		drv_o <= (pos > 6'h2e && pos < 6'h3f) ? mem[ra][6'h3e - pos] : 1'b0;
		if (pos == 6'h3f) begin
			drv_oe <= 1'b0;
			if (hit && op == 2'h1) mem[ra] <= s[15:0];
		end
	end
endmodule : mms_phy
`default_nettype wire

// File: mms_master_bench.sv
// Self-checking bench for the management master
`timescale 1ns/100ps
`default_nettype none
module mms_master_bench;
	import mms_pkg::*;
	localparam logic [4:0] PA = 5'h01;
	logic clk = 0, rstn = 0, link_clk = 0;
	logic reg_sel_data = 0, reg_sel_cmd = 0, reg_wr = 0, reg_rd = 0;
	logic [1:0] reg_be = 0;
	logic [15:0] reg_wdata = 0, reg_rdata, rv, d, c;
	logic mgmt_irq, mgmt_busy, mdc, mdio_o, mdio_oe, drv_o, drv_oe, mdio_i;
	logic [31:0] rnd = 32'h5fb2ceca;
	logic [4:0] ra;
	int err_total = 0, n_tests = 0, cyc = 0;
	// Line level with pull-up
	assign mdio_i = (mdio_oe === 1'b1) ? mdio_o : (drv_oe === 1'b1) ? drv_o : 1'b1;
	always #2 clk = ~clk;
	// Link clock, unrelated phase
	initial begin
		#0.5 link_clk = 1;
		forever #3 link_clk = ~link_clk;
	end
	mms_master #(.HALF_BASE(2)) uut (.clk, .rstn, .link_clk, .reg_sel_data, .reg_sel_cmd,
		.reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .mgmt_irq, .mgmt_busy,
		.mdc, .mdio_i, .mdio_o, .mdio_oe);
	mms_phy #(.PHY_ADDR(PA)) phy (.mdc, .mdio(mdio_i), .drv_o, .drv_oe);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic report_and_stop;
		$display("Checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One register access; read data lands in rv
	task automatic acc(input logic cs, w, input logic [1:0] be, input logic [15:0] v);
		@(negedge clk);
		{reg_sel_cmd, reg_sel_data, reg_wr, reg_rd, reg_be, reg_wdata} = {cs, !cs, w, !w, be, v};
		@(negedge clk);
		{reg_sel_cmd, reg_sel_data, reg_wr, reg_rd} = 4'h0;
		@(negedge clk);
		rv = reg_rdata;
	endtask : acc
	task automatic wait_idle;
		repeat (8000) if (mgmt_busy === 1'b1) @(negedge clk);
	endtask : wait_idle
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			report_and_stop;
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		rstn = 1;
		acc(0, 0, 2'h3, 16'h0);
		chk("data reset", DATA_RESET, rv);
		acc(1, 0, 2'h3, 16'h0);
		chk("cmd reset", {1'b0, CMD_RESET}, rv);
		acc(1, 1, 2'h1, 16'h00e1);
		chk("low byte idle", 16'h0, 16'(mgmt_busy));
		acc(1, 0, 2'h1, 16'h0);
		chk("low byte kept", 16'h00e1, rv);
		for (int k = 0; k < 2; k++) begin
			acc(1, 1, 2'h3, {8'h1f, 3'h0, PA ^ 5'(k * 4)});
			wait_idle;
			acc(0, 0, 2'h3, 16'h0);
			chk("fresh read", k ? 16'hffff : {11'h2d3, 5'h1f}, rv);
		end
		for (int m = 0; m < 8; m++) begin
			rnd = lfsr(rnd);
			{ra, d} = rnd[20:0];
			c = {1'b0, m[0], 1'b1, ra, m[2:0], PA};
			acc(0, 1, 2'h3, d);
			acc(1, 1, 2'h3, c);
			chk("busy", 16'h1, 16'(mgmt_busy));
			acc(0, 1, 2'h3, ~d);
			wait_idle;
			chk("irq", 16'(m[0]), 16'(mgmt_irq));
			acc(1, 0, 2'h3, 16'h0);
			chk("status", c | 16'h8000, rv);
			chk("irq cleared", 16'h0, 16'(mgmt_irq));
			acc(0, 0, 2'h3, 16'h0);
			chk("data kept", d, rv);
			acc(1, 1, 2'h3, c & 16'hdfff);
			acc(1, 0, 2'h1, 16'h0);
			chk("done cleared", 16'h0, 16'(rv[15]));
			wait_idle;
			chk("read irq", 16'(m[0]), 16'(mgmt_irq));
			acc(0, 0, 2'h3, 16'h0);
			chk("read data", d, rv);
		end
		report_and_stop;
	end
endmodule : mms_master_bench
`default_nettype wire
